// ---- ucg_channel.sv ----
// UART channel control, pin multiplexing and notification logic
//
// Contract
// [R01] Received stop character halts transmit
// [R02] Overrun, parity, framing, break flags sticky, read-clear
// [R03] Error bit 7 shows live break
// [R04] Overrun on full FIFO, framing on missing stop
// [R05] All ones breaks forever, zero stops, write aborts
// [R06] Other values break N ms, counting down
// [R07] Finish current character before the break
// [R08] Break starts within 1 ms, stops promptly
// [R09] Hold direction enable for delay bit times
// [R10] Toggle outputs on GPIO9/8, clock on GPIO6
// [R11] Two-bit field picks alternate direction pin use
// [R12] Bit 4 moves direction enable to GPIO7
// [R13] Bit 3 sets direction enable polarity
// [R14] Three-bit field selects five pin modes
// [R15] Direction bits steer GPIO pins only
// [R16] Set and clear registers touch GPIO outputs
// [R17] Level reads all pins, writes GPIO outputs
// [R18] Unmasked input change requests a notification
// [R19] Break interrupt enable and packet format select
// [R20] Standard notification header field values
// [R21] Serial state payload bit layout
// [R22] Pending notification waits for host poll
`timescale 1ns/1ps
module ucg_channel
    import ucg_pkg::*;
#(
    parameter int TICK_CYCLES = UCG_TICK_CYC,
    parameter int PINS = 10
) (
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire ucg_req_t reg_req_in,
    output ucg_rsp_t reg_rsp_out,
    input wire logic rx_byte_valid_in,
    input wire logic [8:0] rx_byte_in,
    input wire logic nine_bit_in,
    input wire logic sw_flow_in,
    input wire logic resume_tx_in,
    input wire logic rx_fifo_full_in,
    input wire logic rx_stop_ok_in,
    input wire logic rx_parity_err_in,
    input wire logic rx_break_now_in,
    input wire logic tx_shifting_in,
    input wire logic tx_busy_in,
    input wire logic addr_match_in,
    input wire logic bit_tick_in,
    input wire logic rx_toggle_in,
    input wire logic tx_toggle_in,
    input wire logic out_clk_in,
    input wire logic rts_n_in,
    input wire logic dtr_n_in,
    input wire logic ring_in,
    input wire logic carrier_in,
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe_out,
    output logic tx_stop_out,
    output logic tx_break_out,
    output logic [7:0] stop_char_out,
    output logic cts_out,
    output logic dsr_out,
    output logic custom_pkt_out,
    input wire logic poll_in,
    output ucg_pkt_t pkt_out,
    output logic nak_out,
    output logic pending_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    logic [9:0] addr;
    logic [15:0] wd;
    logic wr_stop, rd_err, wr_brk, wr_turn, wr_func, wr_dir;
    logic wr_set, wr_clr, wr_lvl, wr_mask, wr_nfy;
    assign addr = reg_req_in.addr;
    assign wd = reg_req_in.wdata;
    assign wr_stop = reg_req_in.wr && addr == UCG_A_STOP;
    assign rd_err = reg_req_in.rd && addr == UCG_A_ERR;
    assign wr_brk = reg_req_in.wr && addr == UCG_A_BRK;
    assign wr_turn = reg_req_in.wr && addr == UCG_A_TURN;
    assign wr_func = reg_req_in.wr && addr == UCG_A_FUNC;
    assign wr_dir = reg_req_in.wr && addr == UCG_A_DIR;
    assign wr_set = reg_req_in.wr && addr == UCG_A_SET;
    assign wr_clr = reg_req_in.wr && addr == UCG_A_CLR;
    assign wr_lvl = reg_req_in.wr && addr == UCG_A_LVL;
    assign wr_mask = reg_req_in.wr && addr == UCG_A_MASK;
    assign wr_nfy = reg_req_in.wr && addr == UCG_A_NFY;

    logic [7:0] stop_r;
    logic [3:0] turn_r;
    logic [9:0] func_r;
    logic [PINS-1:0] dir_r, mask_r, gpo_r;
    logic [1:0] nfy_r;

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            stop_r <= UCG_RST_STOP;
            turn_r <= '0;
            func_r <= UCG_RST_FUNC;
            dir_r <= '0;
            mask_r <= UCG_RST_MASK;
            nfy_r <= '0;
        end else begin
            if (wr_stop) stop_r <= wd[7:0];
            if (wr_turn) turn_r <= wd[3:0];
            if (wr_func) func_r <= wd[9:0];
            if (wr_dir) dir_r <= wd[PINS-1:0];
            if (wr_mask) mask_r <= wd[PINS-1:0];
            if (wr_nfy) nfy_r <= wd[1:0]; // R19
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    logic [PINS-1:0] s1_r, s2_r, prev_r;
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            s1_r <= '0;
            s2_r <= '0;
            prev_r <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            prev_r <= s2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stop character and sticky errors
    logic stop_hit, brk_prev_r;
    logic [6:3] err_r, err_set;
    assign stop_hit = rx_byte_valid_in && sw_flow_in &&
        {rx_byte_in[8] && !nine_bit_in, rx_byte_in[7:0]} ==
        {1'b0, stop_r}; // R01
    assign err_set[UCG_E_OVR] = rx_byte_valid_in && rx_fifo_full_in; // R04
    assign err_set[UCG_E_PAR] = rx_byte_valid_in && rx_parity_err_in;
    assign err_set[UCG_E_FRM] = rx_byte_valid_in && !rx_stop_ok_in; // R04
    assign err_set[UCG_E_BRK] = rx_break_now_in && !brk_prev_r;

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            tx_stop_out <= 1'b0;
            stop_char_out <= UCG_RST_STOP;
            err_r <= '0;
            brk_prev_r <= 1'b0;
        end else begin
            tx_stop_out <= stop_hit || (tx_stop_out && !resume_tx_in); // R01
            stop_char_out <= stop_r;
            brk_prev_r <= rx_break_now_in;
            err_r <= (err_r & ~{4{rd_err}}) | err_set; // R02
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Break generator
    localparam int TW = $clog2(TICK_CYCLES);
    localparam logic [TW-1:0] TICK_END = TW'(TICK_CYCLES - 1);
    logic [TW-1:0] tick_cnt_r;
    logic tick;
    ucg_brk_t brk_st_r;
    logic [15:0] brk_cnt_r;
    assign tick = tick_cnt_r == TICK_END;

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) tick_cnt_r <= '0;
        else tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            brk_st_r <= BRK_IDLE;
            brk_cnt_r <= '0;
        end else if (wr_brk) begin
            brk_cnt_r <= wd; // R05
            brk_st_r <= (wd == 16'h0000) ? BRK_IDLE : BRK_WAIT; // R05
        end else begin
            case (brk_st_r)
                BRK_WAIT: begin
                    if (!tx_shifting_in) brk_st_r <= BRK_ON; // R07 R08
                end
                BRK_ON: begin
                    if (brk_cnt_r == 16'h0000) begin
                        brk_st_r <= BRK_IDLE; // R08
                    end else if (tick && brk_cnt_r != UCG_BRK_CONT) begin
                        brk_cnt_r <= brk_cnt_r - 16'h0001; // R06
                    end
                end
                default: brk_st_r <= BRK_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) tx_break_out <= 1'b0;
        else tx_break_out <= brk_st_r == BRK_ON;
    end

    ////////////////////////////////////////////////////////////////////////
    // Direction enable with turnaround
    logic hold_r;
    logic [3:0] ta_cnt_r;
    logic dir_enable_while_sending, dir_enable_after_match, drive_send;
    logic drive_match;
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            hold_r <= 1'b0;
            ta_cnt_r <= '0;
        end else if (tx_busy_in) begin
            hold_r <= 1'b1;
            ta_cnt_r <= turn_r;
        end else if (hold_r) begin
            if (ta_cnt_r == 4'h0) hold_r <= 1'b0; // R09
            else if (bit_tick_in) ta_cnt_r <= ta_cnt_r - 4'h1; // R09
        end
    end
    assign dir_enable_while_sending = tx_busy_in || hold_r;
    assign dir_enable_after_match = addr_match_in;
    // Polarity 0 gives an active-low enable
    assign drive_send = dir_enable_while_sending ~^ func_r[UCG_F_POL]; // R13
    assign drive_match = dir_enable_after_match ~^ func_r[UCG_F_POL]; // R13

    ////////////////////////////////////////////////////////////////////////
    // Pin function multiplexing
    ucg_pin_mode_t pmode;
    ucg_alt_dir_t amode;
    logic [PINS-1:0] alt_sel, alt_val, alt_oe, gpio_ctl;
    assign pmode = ucg_pin_mode_t'(func_r[2:0]);
    assign amode = ucg_alt_dir_t'(func_r[6:5]);

    always_comb begin
        alt_sel = '0;
        alt_val = '0;
        alt_oe = '0;
        alt_sel[UCG_P_RXT] = func_r[UCG_F_RXT]; // R10
        alt_val[UCG_P_RXT] = rx_toggle_in;
        alt_oe[UCG_P_RXT] = func_r[UCG_F_RXT];
        alt_sel[UCG_P_TXT] = func_r[UCG_F_TXT]; // R10
        alt_val[UCG_P_TXT] = tx_toggle_in;
        alt_oe[UCG_P_TXT] = func_r[UCG_F_TXT];
        alt_sel[UCG_P_CLK] = func_r[UCG_F_CLK]; // R10
        alt_val[UCG_P_CLK] = out_clk_in;
        alt_oe[UCG_P_CLK] = func_r[UCG_F_CLK];
        case (pmode) // R14
            PM_RTS_CTS: begin
                alt_sel[UCG_P_PRI] = 1'b1;
                alt_oe[UCG_P_PRI] = 1'b1;
                alt_val[UCG_P_PRI] = rts_n_in;
                alt_sel[UCG_P_CTS] = 1'b1;
            end
            PM_DTR_DSR: begin
                alt_sel[UCG_P_DTR] = 1'b1;
                alt_oe[UCG_P_DTR] = 1'b1;
                alt_val[UCG_P_DTR] = dtr_n_in;
                alt_sel[UCG_P_DSR] = 1'b1;
            end
            PM_DIR_SEND, PM_DIR_MATCH: begin
                alt_sel[UCG_P_PRI] = 1'b1;
                alt_oe[UCG_P_PRI] = 1'b1;
                alt_val[UCG_P_PRI] =
                    (pmode == PM_DIR_SEND) ? drive_send : drive_match;
            end
            default: ;
        endcase
        // The alternate direction pin stays GPIO while bit 4 is clear
        if (func_r[UCG_F_PIN] &&
            (amode == AD_SEND || amode == AD_MATCH)) begin // R11 R12
            alt_sel[UCG_P_ALT] = 1'b1;
            alt_oe[UCG_P_ALT] = 1'b1;
            alt_val[UCG_P_ALT] =
                (amode == AD_SEND) ? drive_send : drive_match;
        end
    end

    // Only GPIO pins set as outputs take set, clear and level writes
    assign gpio_ctl = dir_r & ~alt_sel;
    logic [PINS-1:0] wbits;
    assign wbits = wd[PINS-1:0] & gpio_ctl;

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) gpo_r <= '0;
        else if (wr_set) gpo_r <= gpo_r | wbits; // R16
        else if (wr_clr) gpo_r <= gpo_r & ~wbits; // R16
        else if (wr_lvl) gpo_r <= (gpo_r & ~gpio_ctl) | wbits; // R17
    end

    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_pin
            always_ff @(posedge ref_clk_in or posedge reset_in) begin
                if (reset_in) begin
                    pin_out[gi] <= 1'b0;
                    pin_oe_out[gi] <= 1'b0;
                end else begin
                    pin_out[gi] <= alt_sel[gi] ? alt_val[gi] : gpo_r[gi];
                    pin_oe_out[gi] <= alt_sel[gi] ? alt_oe[gi] :
                        dir_r[gi]; // R15
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            cts_out <= 1'b0;
            dsr_out <= 1'b0;
            custom_pkt_out <= 1'b0;
        end else begin
            cts_out <= s2_r[UCG_P_CTS];
            dsr_out <= s2_r[UCG_P_DSR];
            custom_pkt_out <= nfy_r[UCG_N_CUST]; // R19
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read answer
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            reg_rsp_out <= '0;
        end else begin
            reg_rsp_out.ack <= reg_req_in.rd || reg_req_in.wr;
            reg_rsp_out.rdata <= '0;
            if (reg_req_in.rd) begin
                case (addr)
                    UCG_A_STOP: reg_rsp_out.rdata <= {8'h00, stop_r};
                    UCG_A_ERR: reg_rsp_out.rdata <=
                        {8'h00, rx_break_now_in, err_r, 3'h0}; // R03
                    UCG_A_BRK: reg_rsp_out.rdata <= brk_cnt_r;
                    UCG_A_TURN: reg_rsp_out.rdata <= {12'h000, turn_r};
                    UCG_A_FUNC: reg_rsp_out.rdata <= {6'h00, func_r};
                    UCG_A_DIR: reg_rsp_out.rdata <= {6'h00, dir_r};
                    UCG_A_LVL: reg_rsp_out.rdata <= {6'h00, s2_r}; // R17
                    UCG_A_MASK: reg_rsp_out.rdata <= {6'h00, mask_r};
                    UCG_A_NFY: reg_rsp_out.rdata <= {14'h0000, nfy_r};
                    default: reg_rsp_out.rdata <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Notification packet
    logic [PINS-1:0] chg;
    logic event_hit, start;
    logic [15:0] state_w, snap_r;
    logic [3:0] idx_r;
    ucg_pk_t pk_st_r;
    assign chg = (s2_r ^ prev_r) & ~pin_oe_out & ~mask_r; // R18
    assign event_hit = (|chg) || (|err_set[6:4]) ||
        (err_set[UCG_E_BRK] && nfy_r[UCG_N_BRK]); // R18 R19
    assign start = poll_in && pending_out && pk_st_r == PK_IDLE;
    assign state_w = {9'h000, err_r[UCG_E_OVR], err_r[UCG_E_PAR],
        err_r[UCG_E_FRM], ring_in, rx_break_now_in, s2_r[UCG_P_DSR],
        carrier_in}; // R21

    function automatic logic [7:0] pk_byte(input logic [3:0] i,
                                           input logic [15:0] p);
        case (i) // R20
            4'h0: pk_byte = UCG_PK_TYPE;
            4'h1: pk_byte = UCG_PK_CODE;
            4'h2: pk_byte = UCG_PK_VALUE[7:0];
            4'h3: pk_byte = UCG_PK_VALUE[15:8];
            4'h4: pk_byte = UCG_PK_INDEX[7:0];
            4'h5: pk_byte = UCG_PK_INDEX[15:8];
            4'h6: pk_byte = UCG_PK_LEN[7:0];
            4'h7: pk_byte = UCG_PK_LEN[15:8];
            4'h8: pk_byte = p[7:0];
            4'h9: pk_byte = p[15:8];
            default: pk_byte = 8'h00;
        endcase
    endfunction

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pending_out <= 1'b0;
            pk_st_r <= PK_IDLE;
            idx_r <= '0;
            snap_r <= '0;
            pkt_out <= '0;
            nak_out <= 1'b0;
        end else begin
            pending_out <= event_hit || (pending_out && !start); // R22
            nak_out <= poll_in && !pending_out && pk_st_r == PK_IDLE;
            pkt_out <= '0;
            case (pk_st_r)
                PK_IDLE: begin
                    if (start) begin // R22
                        snap_r <= state_w;
                        idx_r <= '0;
                        pk_st_r <= PK_SEND;
                    end
                end
                PK_SEND: begin
                    pkt_out.valid <= 1'b1;
                    pkt_out.data <= pk_byte(idx_r, snap_r);
                    pkt_out.last <= idx_r == UCG_PK_LAST;
                    idx_r <= idx_r + 4'h1;
                    if (idx_r == UCG_PK_LAST) pk_st_r <= PK_IDLE;
                end
                default: pk_st_r <= PK_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_brk_go;
        (wr_brk && wd != 16'h0000) ##1 (!tx_shifting_in && !wr_brk);
    endsequence
    sequence s_brk_zero;
        wr_brk && wd == 16'h0000;
    endsequence
    sequence s_poll;
        start;
    endsequence

    stop_match_a: assert property (stop_hit |=> tx_stop_out) // R01
        else $error("stop char did not halt transmit");
    err_clear_a: assert property ((rd_err && !err_set[UCG_E_PAR])
        |=> !err_r[UCG_E_PAR]) // R02
        else $error("parity flag not cleared by read");
    brk_live_a: assert property (rd_err |=>
        reg_rsp_out.rdata[UCG_E_NOW] == $past(rx_break_now_in)) // R03
        else $error("live break bit wrong");
    ovr_flag_a: assert property (err_set[UCG_E_OVR] |=>
        err_r[UCG_E_OVR]) // R04
        else $error("overrun not flagged");
    brk_stop_a: assert property (s_brk_zero |=> ##1 !tx_break_out) // R05
        else $error("zero write did not end break");
    brk_count_a: assert property ((brk_st_r == BRK_ON && tick &&
        brk_cnt_r != UCG_BRK_CONT && brk_cnt_r != 16'h0000 && !wr_brk)
        |=> brk_cnt_r == $past(brk_cnt_r) - 16'h0001) // R06
        else $error("break counter did not decrement");
    brk_hold_a: assert property ((brk_st_r == BRK_WAIT &&
        tx_shifting_in && !wr_brk) |=> brk_st_r == BRK_WAIT) // R07
        else $error("break began during a character");
    brk_start_a: assert property (s_brk_go |=> ##1 tx_break_out) // R08
        else $error("break did not start");
    turn_hold_a: assert property (($fell(tx_busy_in) &&
        $past(turn_r) != 4'h0) |-> dir_enable_while_sending) // R09
        else $error("direction enable dropped early");
    gpio_set_a: assert property (wr_set |=>
        (gpo_r & $past(wbits)) == $past(wbits)) // R16
        else $error("set write missed output");
    pin_change_a: assert property ((|chg) |=> pending_out) // R18
        else $error("pin change not pending");
    pkt_head_a: assert property (s_poll |=> ##1
        (pkt_out.valid && pkt_out.data == UCG_PK_TYPE) ##1
        (pkt_out.valid && pkt_out.data == UCG_PK_CODE)) // R20 R22
        else $error("notification header wrong");
endmodule

// ---- ucg_pkg.sv ----
// Constants and types for the UART channel control and GPIO block
package ucg_pkg;
    // Register offsets
    localparam logic [9:0] UCG_A_STOP = 10'h008;
    localparam logic [9:0] UCG_A_ERR = 10'h009;
    localparam logic [9:0] UCG_A_BRK = 10'h00A;
    localparam logic [9:0] UCG_A_TURN = 10'h00B;
    localparam logic [9:0] UCG_A_FUNC = 10'h00C;
    localparam logic [9:0] UCG_A_DIR = 10'h00D;
    localparam logic [9:0] UCG_A_SET = 10'h00E;
    localparam logic [9:0] UCG_A_CLR = 10'h00F;
    localparam logic [9:0] UCG_A_LVL = 10'h010;
    localparam logic [9:0] UCG_A_MASK = 10'h011;
    localparam logic [9:0] UCG_A_NFY = 10'h012;
    // Reset values and the continuous break count
    localparam logic [7:0] UCG_RST_STOP = 8'h13;
    localparam logic [9:0] UCG_RST_FUNC = 10'h300;
    localparam logic [9:0] UCG_RST_MASK = 10'h100;
    localparam logic [15:0] UCG_BRK_CONT = 16'hFFFF;
    // Error register bits
    localparam int UCG_E_NOW = 7;
    localparam int UCG_E_OVR = 6;
    localparam int UCG_E_PAR = 5;
    localparam int UCG_E_FRM = 4;
    localparam int UCG_E_BRK = 3;
    // Pin function select bits
    localparam int UCG_F_RXT = 9;
    localparam int UCG_F_TXT = 8;
    localparam int UCG_F_CLK = 7;
    localparam int UCG_F_PIN = 4;
    localparam int UCG_F_POL = 3;
    // Notify format bits
    localparam int UCG_N_BRK = 1;
    localparam int UCG_N_CUST = 0;
    // Pin numbers of alternate functions
    localparam int UCG_P_DTR = 2;
    localparam int UCG_P_DSR = 3;
    localparam int UCG_P_CTS = 4;
    localparam int UCG_P_PRI = 5;
    localparam int UCG_P_CLK = 6;
    localparam int UCG_P_ALT = 7;
    localparam int UCG_P_TXT = 8;
    localparam int UCG_P_RXT = 9;
    // Standard notification fields
    localparam logic [7:0] UCG_PK_TYPE = 8'hA1;
    localparam logic [7:0] UCG_PK_CODE = 8'h20;
    localparam logic [15:0] UCG_PK_VALUE = 16'h0000;
    localparam logic [15:0] UCG_PK_INDEX = 16'h0000;
    localparam logic [15:0] UCG_PK_LEN = 16'h0002;
    localparam logic [3:0] UCG_PK_LAST = 4'h9;
    // Break tick timing
    localparam int UCG_CLK_NS = 10;
    localparam int UCG_TICK_MS = 1;
    localparam int UCG_TICK_NS = UCG_TICK_MS * 1000000;
    localparam int UCG_TICK_CYC = UCG_TICK_NS / UCG_CLK_NS;

    typedef enum logic [2:0] {
        PM_GPIO = 3'h0,
        PM_RTS_CTS = 3'h1,
        PM_DTR_DSR = 3'h2,
        PM_DIR_SEND = 3'h3,
        PM_DIR_MATCH = 3'h4
    } ucg_pin_mode_t;
    typedef enum logic [1:0] {
        AD_GPIO = 2'h0,
        AD_SEND = 2'h1,
        AD_MATCH = 2'h2
    } ucg_alt_dir_t;
    typedef enum logic [1:0] {
        BRK_IDLE = 2'h0,
        BRK_WAIT = 2'h1,
        BRK_ON = 2'h2
    } ucg_brk_t;
    typedef enum logic {
        PK_IDLE = 1'b0,
        PK_SEND = 1'b1
    } ucg_pk_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [9:0] addr;
        logic [15:0] wdata;
    } ucg_req_t;
    typedef struct packed {
        logic ack;
        logic [15:0] rdata;
    } ucg_rsp_t;
    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } ucg_pkt_t;
endpackage

// ---- ucg_host_model.sv ----
// Host side model: polls the interrupt endpoint and gathers packets
`timescale 1ns/1ps
module ucg_host_model
    import ucg_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic go_in,
    input wire ucg_pkt_t pkt_in,
    input wire logic nak_in,
    output logic poll_out,
    output logic [79:0] bytes_out,
    output logic [3:0] naks_out
);
    assign poll_out = go_in;
    // Byte 0 ends up in the low byte after a whole packet
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            bytes_out <= 80'h0;
        end else if (pkt_in.valid) begin
            bytes_out <= {pkt_in.data, bytes_out[79:8]};
        end
    end
    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            naks_out <= 4'h0;
        end else if (nak_in) begin
            naks_out <= naks_out + 4'h1;
        end
    end
endmodule

// ---- uart_channel_ctrl_gpio_bench.sv ----
// Register level test of the channel control block
`timescale 1ns/1ps
module uart_channel_ctrl_gpio_bench
    import ucg_pkg::*;
;
    logic clk, rst, rxv, nine, swf, res, full, stp, par, brk, shf, busy;
    logic tick, go, poll, nak, pend, tstop, tbrk, cts, dsr, cust;
    logic ring, car, amatch, rtsn, dtrn;
    logic [8:0] rxb;
    logic [9:0] pin_i, pin_o, pin_oe, ext;
    logic [7:0] sc;
    logic [79:0] pb;
    logic [3:0] naks;
    ucg_req_t req;
    ucg_rsp_t rsp;
    ucg_pkt_t pkt;
    int err_count = 0, total_checks = 0, n;
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext);
    ucg_channel #(.TICK_CYCLES(20), .PINS(10)) DUT (.ref_clk_in(clk),
        .reset_in(rst), .reg_req_in(req), .reg_rsp_out(rsp),
        .rx_byte_valid_in(rxv), .rx_byte_in(rxb), .nine_bit_in(nine),
        .sw_flow_in(swf), .resume_tx_in(res), .rx_fifo_full_in(full),
        .rx_stop_ok_in(stp), .rx_parity_err_in(par),
        .rx_break_now_in(brk), .tx_shifting_in(shf), .tx_busy_in(busy),
        .addr_match_in(amatch), .bit_tick_in(tick), .rx_toggle_in(1'b0),
        .tx_toggle_in(1'b0), .out_clk_in(1'b0), .rts_n_in(rtsn),
        .dtr_n_in(dtrn), .ring_in(ring), .carrier_in(car),
        .pin_in(pin_i), .pin_out(pin_o), .pin_oe_out(pin_oe),
        .tx_stop_out(tstop), .tx_break_out(tbrk), .stop_char_out(sc),
        .cts_out(cts), .dsr_out(dsr), .custom_pkt_out(cust),
        .poll_in(poll), .pkt_out(pkt), .nak_out(nak), .pending_out(pend));
    ucg_host_model HOST (.ref_clk_in(clk), .reset_in(rst), .go_in(go),
        .pkt_in(pkt), .nak_in(nak), .poll_out(poll), .bytes_out(pb),
        .naks_out(naks));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(string nm, logic [79:0] s, logic [79:0] e);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic cyc(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wr(logic [9:0] a, logic [15:0] d);
        req = '{1'b1, 1'b0, a, d};
        cyc(1);
        req = '0;
        cyc(1);
    endtask
    task automatic rd(logic [9:0] a, logic [15:0] e);
        req = '{1'b0, 1'b1, a, 16'h0};
        cyc(1);
        chk("read data", {rsp.ack, rsp.rdata}, {1'b1, e});
        req = '0;
        cyc(1);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        err_count++;
        end_sim();
    end
    initial begin
        {rxv, nine, swf, res, full, stp, par, brk, shf, busy, tick} = '0;
        {go, ext, rxb, req} = '0;
        {amatch, rtsn, dtrn, ring, car} = 5'h03;
        rst = 1'b1;
        cyc(3);
        rst = 1'b0;
        rd(UCG_A_STOP, 16'h0013);
        rd(UCG_A_FUNC, 16'h0300);
        rd(UCG_A_MASK, 16'h0100);
        chk("stop char", sc, 8'h13);
        rd(10'h020, 16'h0000);
        nine = 1'b1;
        swf = 1'b1;
        rxb = 9'h113;
        pulse(rxv);
        cyc(2);
        chk("stop", tstop, 1'b1);
        pulse(res);
        $display("test flow done");
        {full, par, brk} = 3'b111;
        pulse(rxv);
        cyc(3);
        rd(UCG_A_ERR, 16'h00F8);
        rd(UCG_A_ERR, 16'h0080);
        brk = 1'b0;
        cyc(3);
        rd(UCG_A_ERR, 16'h0000);
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(14);
        chk("err pkt", pb, {16'h0009, 16'h0002, 32'h0, 16'h20A1});
        ring = 1'b0;
        ext[0] = 1'b1;
        cyc(4);
        chk("pending", pend, 1'b1);
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(14);
        chk("packet", pb, {16'h0001, 16'h0002, 32'h0, 16'h20A1});
        go = 1'b1;
        cyc(1);
        go = 1'b0;
        cyc(3);
        chk("nak", naks, 4'h1);
        $display("test notify done");
        shf = 1'b1;
        wr(UCG_A_BRK, 16'h0003);
        cyc(10);
        chk("break held", tbrk, 1'b0);
        shf = 1'b0;
        cyc(4);
        chk("break on", tbrk, 1'b1);
        n = 0;
        while (tbrk === 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        chk("break length", (n >= 36 && n <= 66), 1'b1);
        wr(UCG_A_BRK, UCG_BRK_CONT);
        cyc(200);
        chk("break cont", tbrk, 1'b1);
        wr(UCG_A_BRK, 16'h0000);
        chk("break stop", tbrk, 1'b0);
        $display("test break done");
        wr(UCG_A_DIR, 16'h0003);
        wr(UCG_A_SET, 16'h0003);
        cyc(1);
        chk("set", {pin_oe[1:0], pin_o[1:0]}, 4'hF);
        wr(UCG_A_CLR, 16'h0001);
        cyc(1);
        chk("clear", pin_o[1:0], 2'h2);
        cyc(3);
        rd(UCG_A_LVL, 16'h0002);
        wr(UCG_A_LVL, 16'h0000);
        cyc(1);
        chk("level", pin_o[1:0], 2'h0);
        wr(UCG_A_TURN, 16'h0002);
        wr(UCG_A_FUNC, 16'h000B);
        busy = 1'b1;
        cyc(2);
        chk("dir pin", {pin_oe[5], pin_o[5]}, 2'h3);
        busy = 1'b0;
        cyc(3);
        chk("dir hold", pin_o[5], 1'b1);
        pulse(tick);
        cyc(1);
        pulse(tick);
        cyc(3);
        chk("dir drop", pin_o[5], 1'b0);
        ext[4:3] = 2'b11;
        cyc(4);
        chk("modem in", {cts, dsr}, 2'b11);
        wr(UCG_A_NFY, 16'h0001);
        chk("custom", cust, 1'b1);
        $display("test pins done");
        end_sim();
    end
endmodule
